// file: design/strap_decode_pkg.sv
// Constants shared by the strap sampler and address decoder.
// Assumes a 20 MHz master clock and a 32-bit little-endian core bus.
package strap_decode_pkg;
  // ************************************************************
  // Sampling and decode constants.
  // ************************************************************
  // Cycles a strap must hold before the reset release.
  localparam int unsigned STRAP_WINDOW_CYC = 10;
  // Width of the strap window counter.
  localparam int unsigned STRAP_CNT_W = 4;
  // Region boundaries, in address bits 31..22.
  localparam logic [9:0] REGION_LOW = 10'h000;
  localparam logic [9:0] REGION_HIGH = 10'h3ff;
  // Word address width of the 256K byte SRAM (64K words).
  localparam int unsigned SRAM_AW = 16;
  localparam int unsigned SRAM_WORDS = 65536;
  // Internal-region select: bit 20 picks SRAM over boot window.
  localparam int unsigned SRAM_SEL_BIT = 20;
  // Access sizes.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // Reset values of the captured straps (normal boot, 8-bit).
  localparam logic FLOAT_RST = 1'h0;
  localparam logic BOOT8_RST = 1'h1;
  // Decoded region codes.
  typedef enum logic [1:0] {
    RG_SRAM = 2'h0,
    RG_BOOT = 2'h1,
    RG_EXT = 2'h3,
    RG_PERI = 2'h2
  } region_e;
endpackage

// file: design/strap_decode.sv
// Strap sampler, remap state, three-way address decode and on-chip SRAM.
// Assumes straps arrive from board pins and the core bus runs on mclk.
`timescale 1ns/1ns
module strap_decode (
  // Clock and resets.
  input wire logic mclk,
  input wire logic rstn,
  input wire logic watchdog_reset,
  // Shared strap pads (already pin inputs).
  input wire logic output_float_strap,
  input wire logic boot_width_strap,
  // Remap command from the remap control register write.
  input wire logic remap_command_bit,
  // Core bus.
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic bus_fetch,
  input wire logic [1:0] bus_size,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_ack,
  // Region selects toward the rest of the chip.
  output logic ext_sel,
  output logic peri_sel,
  output logic boot_sel,
  output logic [1:0] region,
  // Captured modes.
  output logic float_mode,
  output logic boot_is_8bit,
  output logic chip_id_debug,
  output logic remapped
);
  import strap_decode_pkg::*;

  // ************************************************************
  // Pin synchronisers.
  // ************************************************************
  // Two flops per strap; only the second stage is read.
  logic [1:0] flt_sync_q, flt_sync_d;
  logic [1:0] bw_sync_q, bw_sync_d;

  // Next values: shift the pin level in.
  always_comb begin
    flt_sync_d = {flt_sync_q[0], output_float_strap};
    bw_sync_d = {bw_sync_q[0], boot_width_strap};
  end

  // Register the synchronisers; they keep running through reset.
  always_ff @(posedge mclk) begin
    flt_sync_q <= flt_sync_d;
    bw_sync_q <= bw_sync_d;
  end

  // ************************************************************
  // Reset handling.
  // ************************************************************
  // External reset is sampled as a plain synchronous level; the chip's
  // reset pad logic asserts it asynchronously upstream. Release here is
  // on an mclk edge.
  logic [2:0] rst_dly_q, rst_dly_d;
  logic int_rst;

  // Internal reset: either the external line or the watchdog.
  assign int_rst = !rstn || watchdog_reset;

  // Delay the reset line by the same two stages as the straps, so each strap
  // sample is judged against the reset level of its own cycle. A third stage
  // finds the release; the watchdog never reaches this chain.
  always_comb begin
    rst_dly_d = {rst_dly_q[1:0], rstn};
  end

  always_ff @(posedge mclk) begin
    rst_dly_q <= rst_dly_d;
  end

  // ************************************************************
  // Strap window counters.
  // ************************************************************
  // Count consecutive low (float) and high or low (boot width) samples during
  // external reset; the last ten cycles before release decide.
  logic [STRAP_CNT_W-1:0] flt_low_q, flt_low_d;
  logic [STRAP_CNT_W-1:0] bw_high_q, bw_high_d;
  logic [STRAP_CNT_W-1:0] bw_low_q, bw_low_d;
  logic float_q, float_d;
  logic boot8_q, boot8_d;
  logic release_ext;

  // The aligned reset level has just risen; a watchdog reset never does this.
  assign release_ext = rst_dly_q[1] && !rst_dly_q[2];

  // Saturating run counters; the straps act as straps only here.
  always_comb begin
    flt_low_d = flt_low_q;
    bw_high_d = bw_high_q;
    bw_low_d = bw_low_q;
    if (!rst_dly_q[1]) begin
      flt_low_d = flt_sync_q[1] ? '0 :
        (flt_low_q == STRAP_CNT_W'(STRAP_WINDOW_CYC)) ? flt_low_q : flt_low_q + 1'b1;
      bw_high_d = !bw_sync_q[1] ? '0 :
        (bw_high_q == STRAP_CNT_W'(STRAP_WINDOW_CYC)) ? bw_high_q : bw_high_q + 1'b1;
      bw_low_d = bw_sync_q[1] ? '0 :
        (bw_low_q == STRAP_CNT_W'(STRAP_WINDOW_CYC)) ? bw_low_q : bw_low_q + 1'b1;
    end else begin
      // Start every window from zero. The counts hold no reset value, so the
      // very first power-up reset should run well past the ten-cycle window.
      flt_low_d = '0;
      bw_high_d = '0;
      bw_low_d = '0;
    end
  end

  // Capture on the rising edge of external reset only.
  always_comb begin
    float_d = float_q;
    boot8_d = boot8_q;
    if (release_ext) begin
      // Ten low cycles enter the output-float debug mode.
      float_d = (flt_low_q == STRAP_CNT_W'(STRAP_WINDOW_CYC));
      // A steady high selects 8-bit boot and a steady low 16-bit; a strap
      // that moved inside the window falls back to the 8-bit default.
      if (bw_high_q == STRAP_CNT_W'(STRAP_WINDOW_CYC)) begin
        boot8_d = 1'b1;
      end else if (bw_low_q == STRAP_CNT_W'(STRAP_WINDOW_CYC)) begin
        boot8_d = 1'b0;
      end else begin
        boot8_d = BOOT8_RST;
      end
    end
  end

  // Counters and captured straps; strap flops are never touched by the
  // watchdog, so a watchdog reset keeps the old modes.
  always_ff @(posedge mclk) begin
    flt_low_q <= flt_low_d;
    bw_high_q <= bw_high_d;
    bw_low_q <= bw_low_d;
    float_q <= float_d;
    boot8_q <= boot8_d;
  end

  assign float_mode = float_q;
  assign boot_is_8bit = boot8_q;
  // Debug mode makes the core report its own chip identifier.
  assign chip_id_debug = float_q;

  // ************************************************************
  // Remap state.
  // ************************************************************
  logic remap_q, remap_d;

  // Set by the remap command; only a reset of either kind clears it.
  always_comb begin
    remap_d = remap_q;
    if (int_rst) begin
      remap_d = 1'b0;
    end else if (remap_command_bit) begin
      remap_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    remap_q <= remap_d;
  end

  assign remapped = remap_q;

  // ************************************************************
  // Address decode.
  // ************************************************************
  region_e region_c;

  // Top ten address bits split the 4G space into three parts.
  always_comb begin
    if (bus_addr[31:22] == REGION_HIGH) begin
      region_c = RG_PERI;
    end else if (bus_addr[31:22] != REGION_LOW) begin
      region_c = RG_EXT;
    end else if (remap_q || bus_addr[SRAM_SEL_BIT]) begin
      region_c = RG_SRAM;
    end else begin
      // Before remap, zero maps to boot memory on chip select zero,
      // which is reached through the external bus unit.
      region_c = RG_BOOT;
    end
  end

  assign region = region_c;
  assign ext_sel = bus_req && !int_rst && (region_c == RG_EXT || region_c == RG_BOOT);
  assign peri_sel = bus_req && !int_rst && (region_c == RG_PERI);
  assign boot_sel = bus_req && !int_rst && (region_c == RG_BOOT);

  // ************************************************************
  // On-chip SRAM.
  // ************************************************************
  // 64K words of 32 bits, little-endian lanes, one cycle per access.
  logic [31:0] lane_rd; // Word gathered from the four lane memories.
  logic [3:0] lane_en;
  logic [31:0] wdata_lanes;
  logic [SRAM_AW-1:0] widx;
  logic sram_hit;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;

  assign widx = bus_addr[SRAM_AW+1:2];
  assign sram_hit = bus_req && !int_rst && (region_c == RG_SRAM);

  // Byte lanes: byte 0 sits in bits 7..0, no big-endian option.
  always_comb begin
    case (bus_size)
      SIZE_BYTE: begin
        lane_en = 4'h1 << bus_addr[1:0];
        wdata_lanes = {4{bus_wdata[7:0]}};
      end
      SIZE_HALF: begin
        lane_en = bus_addr[1] ? 4'hc : 4'h3;
        wdata_lanes = {2{bus_wdata[15:0]}};
      end
      default: begin
        lane_en = 4'hf;
        wdata_lanes = bus_wdata;
      end
    endcase
  end

  // Per-lane memories, one generate loop over the four bytes. Each lane owns
  // its array, so no two processes ever write the same variable.
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] lane_mem [SRAM_WORDS]; // One byte of every word.
    always_ff @(posedge mclk) begin
      if (sram_hit && bus_we && lane_en[b]) begin
        lane_mem[widx] <= wdata_lanes[8*b+:8];
      end
    end
    assign lane_rd[8*b+:8] = lane_mem[widx];
  end

  // Fetches of either instruction width and data reads look alike.
  always_comb begin
    rdata_d = rdata_q;
    ack_d = sram_hit;
    if (sram_hit && !bus_we) begin
      rdata_d = lane_rd;
    end
  end

  always_ff @(posedge mclk) begin
    if (int_rst) begin
      rdata_q <= '0;
      ack_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign bus_ack = ack_q;

  // ************************************************************
  // Assertions.
  // ************************************************************
  sequence s_float_low10;
    (!flt_sync_q[1] && !rst_dly_q[1]) [*8] ##1 (!flt_sync_q[1] && !rst_dly_q[1])
      ##1 (!flt_sync_q[1] && !rst_dly_q[1]);
  endsequence

  float_capture_a: assert property (@(posedge mclk)
    s_float_low10 ##1 release_ext |=> float_mode)
    else $error("float mode not entered after ten low cycles");

  boot_width_a: assert property (@(posedge mclk)
    release_ext && bw_low_q == STRAP_CNT_W'(STRAP_WINDOW_CYC) |=> !boot_is_8bit)
    else $error("low boot strap did not select 16-bit boot");

  wdog_keep_a: assert property (@(posedge mclk)
    rstn && watchdog_reset |=> $stable(float_mode) && $stable(boot_is_8bit))
    else $error("watchdog reset changed captured straps");

  remap_hold_a: assert property (@(posedge mclk) disable iff (int_rst)
    remapped |=> remapped)
    else $error("remap dropped without reset");

  peri_region_a: assert property (@(posedge mclk)
    bus_addr[31:22] == REGION_HIGH |-> region == RG_PERI)
    else $error("top region not routed to peripherals");

  ext_region_a: assert property (@(posedge mclk) disable iff (int_rst)
    bus_req && bus_addr[31:22] != REGION_LOW && bus_addr[31:22] != REGION_HIGH |-> ext_sel)
    else $error("middle region not routed to external bus");

  boot_zero_a: assert property (@(posedge mclk) disable iff (int_rst)
    !remapped && bus_req && bus_addr == 32'h0000_0000 |-> boot_sel)
    else $error("address zero not boot memory before remap");

  sram_one_cycle_a: assert property (@(posedge mclk) disable iff (int_rst)
    sram_hit |=> bus_ack)
    else $error("SRAM access took more than one cycle");

  fetch_ack_a: assert property (@(posedge mclk) disable iff (int_rst)
    sram_hit && bus_fetch && !bus_we |=> bus_ack && bus_rdata == $past(lane_rd))
    else $error("instruction fetch from SRAM not answered next cycle");

  sram_zero_a: assert property (@(posedge mclk) disable iff (int_rst)
    remapped && bus_req && bus_addr[31:22] == REGION_LOW |-> region == RG_SRAM)
    else $error("SRAM not at zero after remap");
endmodule // strap_decode

// file: tb/strap_board.sv
// Board model for the two strap pads: pull-ups, plus jumpers the bench fits.
// Assumes the bench changes jumpers only while rstn is low.
`timescale 1ns/1ns
module strap_board (
  // Clock and reset seen by the board.
  input wire logic mclk,
  input wire logic rstn,
  // Jumpers from the bench; high pulls a pad low.
  input wire logic float_jumper,
  input wire logic boot_jumper,
  // Strap pads.
  output logic output_float_strap,
  output logic boot_width_strap
);
  // ************************************************************
  // Pad levels.
  // ************************************************************
  logic pad_q; // Io traffic once the pads are reused.
  // After reset the pads carry io and serial traffic, so they toggle.
  always_ff @(posedge mclk) begin
    pad_q <= rstn ? ~pad_q : 1'b0;
  end
  // The pull-up holds a strap high unless its jumper is fitted.
  assign output_float_strap = rstn ? pad_q : ~float_jumper;
  assign boot_width_strap = rstn ? ~pad_q : ~boot_jumper;
endmodule // strap_board

// file: tb/strap_decode_tb.sv
// Self-checking bench for the strap sampler, decoder and SRAM.
// Assumes the board model in strap_board and the shared package.
`timescale 1ns/1ns
module strap_decode_tb;
  import strap_decode_pkg::*;
  // ************************************************************
  // Signals.
  // ************************************************************
  logic mclk = 1'b0, rstn = 1'b0, watchdog_reset = 1'b0, remap_command_bit = 1'b0;
  logic float_jumper = 1'b0, boot_jumper = 1'b0, output_float_strap, boot_width_strap;
  logic bus_req = 1'b0, bus_we = 1'b0, bus_fetch = 1'b0;
  logic [1:0] bus_size = SIZE_WORD;
  logic [31:0] bus_addr = 32'h0000_0000, bus_wdata = 32'h0000_0000, bus_rdata, rd;
  logic bus_ack, ext_sel, peri_sel, boot_sel, float_mode, boot_is_8bit;
  logic chip_id_debug, remapped;
  logic [1:0] region;
  int err_total = 0, checks_done = 0;
  // Probe addresses at both edges of every region.
  logic [31:0] probe [7] = '{32'h0000_0000, 32'h0010_0000, 32'h003F_FFFC, 32'h0040_0000,
    32'hFFBF_FFFC, 32'hFFC0_0000, 32'hFFFF_FFFC};
  always #25 mclk = ~mclk;
  strap_board board (.mclk(mclk), .rstn(rstn), .float_jumper(float_jumper),
    .boot_jumper(boot_jumper), .output_float_strap(output_float_strap),
    .boot_width_strap(boot_width_strap));
  strap_decode DUT (.mclk(mclk), .rstn(rstn), .watchdog_reset(watchdog_reset),
    .output_float_strap(output_float_strap), .boot_width_strap(boot_width_strap),
    .remap_command_bit(remap_command_bit), .bus_req(bus_req), .bus_we(bus_we),
    .bus_fetch(bus_fetch), .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .ext_sel(ext_sel), .peri_sel(peri_sel),
    .boot_sel(boot_sel), .region(region), .float_mode(float_mode),
    .boot_is_8bit(boot_is_8bit), .chip_id_debug(chip_id_debug), .remapped(remapped));
  // ************************************************************
  // Shared tasks.
  // ************************************************************
  // Compare with case equality so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hold reset long enough for sync plus window; float jumper only for the last cycles.
  task automatic reset_run(input int float_lo, input logic boot_lo);
    rstn <= 1'b0;
    float_jumper <= (float_lo >= 16);
    boot_jumper <= boot_lo;
    repeat (16 - float_lo) @(posedge mclk);
    if (float_lo < 16) float_jumper <= (float_lo > 0);
    repeat (float_lo) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  // One SRAM access; the answer stands for the cycle after the taking edge.
  task automatic acc(input logic we, input logic [1:0] sz, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge mclk);
    bus_req <= 1'b1;
    bus_we <= we;
    bus_fetch <= ~we;
    bus_size <= sz;
    bus_addr <= a;
    bus_wdata <= wd;
    @(posedge mclk);
    bus_req <= 1'b0;
    #1;
    chk("bus_ack", bus_ack, 1);
    rd = bus_rdata;
  endtask
  // Walk the probe table; expectations follow the region map.
  task automatic decode_all(input logic rm);
    logic [1:0] er;
    foreach (probe[i]) begin
      @(posedge mclk);
      bus_req <= 1'b1;
      bus_we <= 1'b0;
      bus_addr <= probe[i];
      #1;
      er = probe[i][31:22] == REGION_LOW ? ((rm || probe[i][20]) ? RG_SRAM : RG_BOOT)
         : (probe[i][31:22] == REGION_HIGH ? RG_PERI : RG_EXT);
      chk("region", region, er);
      chk("ext_sel", ext_sel, er == RG_EXT || er == RG_BOOT);
      chk("peri_sel", peri_sel, er == RG_PERI);
      chk("boot_sel", boot_sel, er == RG_BOOT);
      @(posedge mclk);
      bus_req <= 1'b0;
    end
  endtask
  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic t_straps();
    reset_run(16, 1'b1);
    chk("float_mode", float_mode, 1);
    chk("chip_id_debug", chip_id_debug, 1);
    chk("boot_is_8bit", boot_is_8bit, 0);
    repeat (20) @(posedge mclk);
    #1;
    chk("float_mode held", float_mode, 1);
    chk("boot held", boot_is_8bit, 0);
    reset_run(10, 1'b0);
    chk("float_mode ten", float_mode, 1);
    reset_run(9, 1'b0);
    chk("float_mode short", float_mode, 0);
    chk("boot_is_8bit", boot_is_8bit, 1);
  endtask
  task automatic t_sram();
    acc(1, SIZE_WORD, 32'h0010_0000, 32'h1122_3344);
    acc(1, SIZE_BYTE, 32'h0010_0001, 32'hAAAA_AAAA);
    acc(1, SIZE_HALF, 32'h0010_0002, 32'hBEEF_BEEF);
    acc(0, SIZE_WORD, 32'h0010_0000, 32'h0000_0000);
    chk("lanes", rd, 32'hBEEF_AA44);
    acc(1, SIZE_WORD, 32'h0013_FFFC, 32'h0BAD_F00D);
    acc(0, SIZE_WORD, 32'h0013_FFFC, 32'h0000_0000);
    chk("top word", rd, 32'h0BAD_F00D);
  endtask
  task automatic remap_on();
    @(posedge mclk);
    remap_command_bit <= 1'b1;
    @(posedge mclk);
    remap_command_bit <= 1'b0;
    @(posedge mclk);
    #1;
    chk("remapped", remapped, 1);
  endtask
  task automatic t_remap();
    decode_all(1'b0);
    remap_on();
    decode_all(1'b1);
    acc(1, SIZE_WORD, 32'h0000_0000, 32'h5566_7788);
    acc(0, SIZE_WORD, 32'h0000_0000, 32'h0000_0000);
    chk("vector word", rd, 32'h5566_7788);
    @(posedge mclk);
    watchdog_reset <= 1'b1;
    @(posedge mclk);
    watchdog_reset <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("remap after wdog", remapped, 0);
    chk("float after wdog", float_mode, 0);
    chk("boot after wdog", boot_is_8bit, 1);
    remap_on();
    reset_run(0, 1'b0);
    chk("remap after rstn", remapped, 0);
  endtask
  initial begin
    // Power-up reset of two cycles with both jumpers off.
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    t_straps();
    t_sram();
    t_remap();
    conclude();
  end
endmodule // strap_decode_tb
